// >>> logic/tcb_pkg.sv
// Shared constants for the transfer controller bus-timing sequencer.
// Assumes one system bus clock shared with the arbiter and bus targets.
package tcb_pkg;
   // Target classes
   localparam logic [1:0] REG_RAM = 2'h0;
   localparam logic [1:0] REG_IO  = 2'h1;
   localparam logic [1:0] REG_EXT = 2'h2;
   // Access sizes, log2 of bytes
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;
   localparam logic [1:0] SZ_LONG = 2'h2;
   // Bus widths, log2 of bytes
   localparam logic [1:0] BW_8  = 2'h0;
   localparam logic [1:0] BW_16 = 2'h1;
   localparam logic [1:0] BW_32 = 2'h2;
   // Access counts per phase
   localparam logic [2:0] VEC_READS     = 3'h1;
   localparam logic [2:0] DESC_RD_FULL  = 3'h4;
   localparam logic [2:0] DESC_RD_SHORT = 3'h3;
   localparam logic [2:0] WB_NORMAL     = 3'h3;
   localparam logic [2:0] WB_ONE_FIXED  = 3'h2;
   localparam logic [2:0] WB_BOTH_FIXED = 3'h1;
   localparam logic [2:0] SPLIT_THREE   = 3'h3;
   localparam logic [2:0] SPLIT_TWO     = 3'h2;
   localparam logic [2:0] SPLIT_ONE     = 3'h1;
   localparam logic [2:0] INT_OPS       = 3'h1;
   // Cycle costs
   localparam logic [6:0] RAM_CYCLES     = 7'h01;
   localparam logic [6:0] IO_PER_UNIT    = 7'h02;
   localparam logic [6:0] EXT2_PER_UNIT  = 7'h02;
   localparam logic [6:0] EXT3_PER_UNIT  = 7'h03;
   localparam logic [6:0] EXT3_WORD8_FIX = 7'h04;
   localparam logic [6:0] INT_OP_CYCLES  = 7'h01;
   // Block size field value 0 stands for the largest block
   localparam logic [8:0] BLOCK_MAX = 9'h100;
   // Sequencer states, Gray in declaration order
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_REQ  = 3'h1,
      ST_VEC  = 3'h3,
      ST_DRD  = 3'h2,
      ST_DATA = 3'h6,
      ST_WB   = 3'h7,
      ST_INT  = 3'h5,
      ST_REL  = 3'h4
   } tcb_state_t;
endpackage : tcb_pkg

// >>> logic/tcb_access_cost.sv
// Cycle cost of one bus access for a target class, size and bus width.
// Assumes width and wait settings are stable while an access runs.
`timescale 1ns/1ps
module tcb_access_cost
   import tcb_pkg::*;
(
   input  wire logic [1:0] region,
   input  wire logic [1:0] size,
   input  wire logic [1:0] ioWidth,
   input  wire logic [1:0] extWidth,
   input  wire logic       threeState,
   input  wire logic [2:0] waitCount,
   output logic      [6:0] cost
);
   // Bus-width units needed for one item
   function automatic logic [6:0] unitsOf(input logic [1:0] sz, input logic [1:0] bw);
      if (sz > bw) unitsOf = 7'h01 << (sz - bw);
      else unitsOf = 7'h01;
   endfunction : unitsOf

   // Word on a narrow three-state bus costs less than two full units
   always_comb begin
      logic [6:0] u;
      u = 7'h00;
      cost = RAM_CYCLES;
      if (region == REG_IO) begin
         u = unitsOf(size, ioWidth);
         cost = 7'(IO_PER_UNIT * u);
      end else if (region == REG_EXT) begin
         u = unitsOf(size, extWidth);
         if (!threeState) cost = 7'(EXT2_PER_UNIT * u);
         else if (size == SZ_WORD && extWidth == BW_8)
            cost = 7'(EXT3_WORD8_FIX + 7'(2 * waitCount));
         else cost = 7'(u * (EXT3_PER_UNIT + 7'(waitCount)));
      end
   end
endmodule : tcb_access_cost

// >>> logic/tcb_transfer_controller.sv
// Transfer controller sequencer: phase order, access counts, cycle costs
// and bus mastership handling for one activation and its chain.
// Assumes arbiter grant and descriptor settings come from logic on mclk.
`timescale 1ns/1ps
module tcb_transfer_controller
   import tcb_pkg::*;
#(
   parameter int CYC_W = 16
)(
   input  wire logic             mclk,
   input  wire logic             srst,
   input  wire logic             actReq,
   input  wire logic [2:0]       cpuPriorityLevel,
   input  wire logic [2:0]       controllerPriorityLevel,
   input  wire logic             busGrant,
   input  wire logic             fullAddrMode,
   input  wire logic             skipDescRead,
   input  wire logic [1:0]       infoRegion,
   input  wire logic [1:0]       srcRegion,
   input  wire logic [1:0]       dstRegion,
   input  wire logic [1:0]       ioWidth,
   input  wire logic [1:0]       extWidth,
   input  wire logic             threeState,
   input  wire logic [2:0]       waitCount,
   input  wire logic             srcFixed,
   input  wire logic             dstFixed,
   input  wire logic             blockMode,
   input  wire logic [7:0]       blockSize,
   input  wire logic [1:0]       dataSize,
   input  wire logic [1:0]       srcAddrLow,
   input  wire logic [1:0]       dstAddrLow,
   input  wire logic             chainEnable,
   output logic                  busReq,
   output logic                  busy,
   output logic                  accessStrobe,
   output logic                  activationDone,
   output tcb_state_t            phase,
   output logic [CYC_W-1:0]      cycleTotal,
   output logic [7:0]            descCount
);
   tcb_state_t       state, next_state, resume, next_resume;
   logic             next_busReq, next_busy, next_accessStrobe, next_activationDone;
   logic             pending, next_pending, writeStage, next_writeStage, actSkip, next_actSkip;
   logic [2:0]       accLeft, next_accLeft;
   logic [6:0]       costCnt, next_costCnt, accCost;
   logic [8:0]       elemLeft, next_elemLeft;
   logic [CYC_W-1:0] next_cycleTotal;
   logic [7:0]       next_descCount;
   logic             dFixS, dFixD, dChain, next_dFixS, next_dFixD, next_dChain;
   logic [1:0]       dSize, dSrcLow, dDstLow, next_dSize, next_dSrcLow, next_dDstLow;
   logic [8:0]       dElems, next_dElems;
   logic [1:0]       curRegion, curSize;
   logic             accessEnd, startAct, loadDesc;
   // Accesses a data item splits into
   function automatic logic [2:0] splitOf(input logic [1:0] sz, input logic [1:0] lo);
      if (sz == SZ_LONG && lo[0]) splitOf = SPLIT_THREE;
      else if ((sz == SZ_WORD && lo[0]) || (sz == SZ_LONG && lo == 2'h2))
         splitOf = SPLIT_TWO;
      else splitOf = SPLIT_ONE;
   endfunction : splitOf
   // Writeback accesses by fixed-address settings
   function automatic logic [2:0] wbOf(input logic fs, input logic fd);
      if (fs && fd) wbOf = WB_BOTH_FIXED;
      else if (fs || fd) wbOf = WB_ONE_FIXED;
      else wbOf = WB_NORMAL;
   endfunction : wbOf
   // Target and size of the access now running; data size from the descriptor
   always_comb begin
      curRegion = (state == ST_INT) ? REG_RAM : infoRegion;
      curSize = SZ_LONG;
      if (state == ST_DATA) begin
         curRegion = writeStage ? dstRegion : srcRegion;
         curSize = dSize;
      end
   end
   tcb_access_cost u_cost (
      .region     (curRegion),
      .size       (curSize),
      .ioWidth    (ioWidth),
      .extWidth   (extWidth),
      .threeState (threeState),
      .waitCount  (waitCount),
      .cost       (accCost)
   );
   // Access completes on the cycle its cost is reached, only while granted
   assign accessEnd = busGrant && costCnt == accCost &&
                      (state == ST_VEC || state == ST_DRD || state == ST_DATA ||
                       state == ST_WB || state == ST_INT);
   assign startAct = state == ST_IDLE && (pending || actReq) &&
                     controllerPriorityLevel >= cpuPriorityLevel;
   assign loadDesc = (startAct && skipDescRead) ||
                     (state == ST_DRD && accessEnd && accLeft == 3'h1);

   // Sequencer next state
   always_comb begin
      next_state = state;
      next_resume = resume;
      next_busy = busy;
      next_accessStrobe = 1'b0;
      next_activationDone = 1'b0;
      next_writeStage = writeStage;
      next_actSkip = actSkip;
      next_accLeft = accLeft;
      next_costCnt = costCnt;
      next_elemLeft = elemLeft;
      next_cycleTotal = cycleTotal;
      next_descCount = descCount;
      // A request that lands as one is consumed is kept
      next_pending = actReq ? !(startAct && !pending) : (pending && !startAct);
      if (busGrant && state != ST_IDLE && state != ST_REQ && state != ST_REL)
         next_cycleTotal = cycleTotal + 1'b1;
      case (state)
         ST_IDLE: begin
            if (startAct) begin
               next_state = ST_REQ;
               next_busy = 1'b1;
               next_actSkip = skipDescRead;
               next_resume = skipDescRead ? ST_DATA : ST_VEC;
               next_cycleTotal = '0;
               next_descCount = 8'h01;
               next_writeStage = 1'b0;
               next_elemLeft = next_dElems;
            end
         end
         ST_REQ: begin
            if (busGrant) begin
               next_state = resume;
               next_costCnt = 7'h01;
               case (resume)
                  ST_VEC:  next_accLeft = VEC_READS;
                  ST_DRD:  next_accLeft = fullAddrMode ? DESC_RD_FULL : DESC_RD_SHORT;
                  ST_DATA: next_accLeft = splitOf(dSize, dSrcLow);
                  default: next_accLeft = wbOf(dFixS, dFixD);
               endcase
            end
         end
         ST_REL: begin
            // Bus offered back for one cycle before asking again
            next_state = (resume == ST_IDLE) ? ST_IDLE : ST_REQ;
            next_busy = resume != ST_IDLE;
            next_activationDone = resume == ST_IDLE;
         end
         default: begin
            if (busGrant && !accessEnd) begin
               next_costCnt = costCnt + 7'h01;
            end else if (accessEnd) begin
               next_costCnt = 7'h01;
               next_accessStrobe = state != ST_INT;
               if (accLeft > 3'h1) begin
                  next_accLeft = accLeft - 3'h1;
               end else begin
                  case (state)
                     ST_VEC: begin
                        next_state = ST_REL;
                        next_resume = ST_DRD;
                     end
                     ST_DRD: begin
                        next_state = ST_REL;
                        next_resume = ST_DATA;
                        next_elemLeft = next_dElems;
                        next_writeStage = 1'b0;
                     end
                     ST_DATA: begin
                        if (!writeStage) begin
                           next_writeStage = 1'b1;
                           next_accLeft = splitOf(dSize, dDstLow);
                        end else begin
                           next_writeStage = 1'b0;
                           next_elemLeft = elemLeft - 9'h001;
                           next_state = ST_REL;
                           next_resume = (elemLeft > 9'h001) ? ST_DATA : ST_WB;
                        end
                     end
                     ST_WB: begin
                        if (dChain) begin
                           next_state = ST_REL;
                           next_resume = ST_DRD;
                           next_descCount = descCount + 8'h01;
                        end else if (!actSkip) begin
                           next_state = ST_INT;
                           next_accLeft = INT_OPS;
                        end else begin
                           next_state = ST_REL;
                           next_resume = ST_IDLE;
                        end
                     end
                     default: begin
                        next_state = ST_REL;
                        next_resume = ST_IDLE;
                     end
                  endcase
               end
            end
         end
      endcase
      next_busReq = next_state != ST_IDLE && next_state != ST_REL;
   end

   // Descriptor fields caught once per descriptor
   always_comb begin
      next_dFixS = dFixS;
      next_dFixD = dFixD;
      next_dChain = dChain;
      next_dSize = dSize;
      next_dSrcLow = dSrcLow;
      next_dDstLow = dDstLow;
      next_dElems = dElems;
      if (loadDesc) begin
         next_dFixS = srcFixed;
         next_dFixD = dstFixed;
         next_dChain = chainEnable;
         next_dSize = dataSize;
         next_dSrcLow = srcAddrLow;
         next_dDstLow = dstAddrLow;
         if (!blockMode) next_dElems = 9'h001;
         else if (blockSize == 8'h00) next_dElems = BLOCK_MAX;
         else next_dElems = {1'b0, blockSize};
      end
   end

   // State registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         state <= ST_IDLE;
         resume <= ST_IDLE;
         busReq <= 1'b0;
         busy <= 1'b0;
         accessStrobe <= 1'b0;
         activationDone <= 1'b0;
         phase <= ST_IDLE;
         pending <= 1'b0;
         writeStage <= 1'b0;
         actSkip <= 1'b0;
         accLeft <= 3'h0;
         costCnt <= 7'h01;
         elemLeft <= 9'h000;
         cycleTotal <= '0;
         descCount <= 8'h00;
         dFixS <= 1'b0;
         dFixD <= 1'b0;
         dChain <= 1'b0;
         dSize <= SZ_BYTE;
         dSrcLow <= 2'h0;
         dDstLow <= 2'h0;
         dElems <= 9'h001;
      end else begin
         state <= next_state;
         resume <= next_resume;
         busReq <= next_busReq;
         busy <= next_busy;
         accessStrobe <= next_accessStrobe;
         activationDone <= next_activationDone;
         phase <= next_state;
         pending <= next_pending;
         writeStage <= next_writeStage;
         actSkip <= next_actSkip;
         accLeft <= next_accLeft;
         costCnt <= next_costCnt;
         elemLeft <= next_elemLeft;
         cycleTotal <= next_cycleTotal;
         descCount <= next_descCount;
         dFixS <= next_dFixS;
         dFixD <= next_dFixD;
         dChain <= next_dChain;
         dSize <= next_dSize;
         dSrcLow <= next_dSrcLow;
         dDstLow <= next_dDstLow;
         dElems <= next_dElems;
      end
   end

   // Checking helpers: accesses done in the current phase, per-activation counts
   logic [2:0] hPhaseCnt;
   logic [1:0] hVecCnt, hIntCnt;
   always_ff @(posedge mclk) begin
      if (srst || startAct) begin
         hPhaseCnt <= 3'h0;
         hVecCnt <= 2'h0;
         hIntCnt <= 2'h0;
      end else begin
         if (next_state != state || next_writeStage != writeStage) hPhaseCnt <= 3'h0;
         else if (accessEnd) hPhaseCnt <= hPhaseCnt + 3'h1;
         if (accessEnd && state == ST_VEC) hVecCnt <= hVecCnt + 2'h1;
         if (accessEnd && state == ST_INT) hIntCnt <= hIntCnt + 2'h1;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   vec_int_count_a: assert property (activationDone |->
      hVecCnt == {1'b0, !actSkip} && hIntCnt == {1'b0, !actSkip})
      else $error("vector read or internal op count wrong");
   desc_read_len_a: assert property (state == ST_DRD && accessEnd && accLeft == 3'h1 |->
      hPhaseCnt == (fullAddrMode ? 3'h3 : 3'h2))
      else $error("descriptor read access count wrong");
   writeback_len_a: assert property (state == ST_WB && accessEnd && accLeft == 3'h1 |->
      hPhaseCnt + 3'h1 == wbOf(dFixS, dFixD))
      else $error("writeback access count wrong");
   odd_long_split_a: assert property (state == ST_DATA && accessEnd && accLeft == 3'h1 &&
      !writeStage && dSize == SZ_LONG && dSrcLow[0] |-> hPhaseCnt == 3'h2)
      else $error("odd longword read not split in three");
   ram_one_cycle_a: assert property (curRegion == REG_RAM |-> accCost == 7'h01)
      else $error("on-chip RAM access not one cycle");
   ext_long8_cost_a: assert property (curRegion == REG_EXT && threeState &&
      curSize == SZ_LONG && extWidth == BW_8 |-> accCost == 7'(12 + 4 * waitCount))
      else $error("external longword cost wrong");
   grant_before_access_a: assert property (accessStrobe |-> $past(busGrant) && $past(busReq))
      else $error("access without grant");
   vector_release_a: assert property (state == ST_VEC && accessEnd |=> !busReq ##1 busReq)
      else $error("bus not offered back after vector read");
   atomic_phase_a: assert property (state inside {ST_DRD, ST_WB} && accessEnd &&
      accLeft > 3'h1 |=> busReq && state == $past(state))
      else $error("bus released inside atomic phase");
   priority_gate_a: assert property ($rose(busy) |->
      $past(controllerPriorityLevel) >= $past(cpuPriorityLevel))
      else $error("activation served against priority");
   chain_next_a: assert property (state == ST_WB && accessEnd && accLeft == 3'h1 && dChain |=>
      state == ST_REL && resume == ST_DRD ##1 state == ST_REQ && busy)
      else $error("chain did not continue");
   chain_cover: cover property (state == ST_WB && accessEnd && dChain);
   block_cover: cover property (state == ST_DATA && writeStage && accessEnd && elemLeft > 9'h001);
   skip_cover: cover property (activationDone && actSkip);
   done_cover: cover property (activationDone && !actSkip);
endmodule : tcb_transfer_controller

// >>> tb/tcb_arbiter_model.sv
// Behavioural bus arbiter facing the transfer controller.
// Assumes requests come from logic on mclk; slow mode withholds grant at random.
`timescale 1ns/1ps
module tcb_arbiter_model (
   input  wire logic mclk,
   input  wire logic srst,
   input  wire logic busReq,
   input  wire logic slowGrant,
   output logic      busGrant
);
   logic [7:0] lfsr;

   // Grant follows request; a slow arbiter also stalls accesses mid-way
   always_ff @(posedge mclk) begin
      if (srst) begin
         lfsr     <= 8'ha5;
         busGrant <= 1'b0;
      end else begin
         lfsr     <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         busGrant <= busReq && (!slowGrant || lfsr[0]);
      end
   end
endmodule : tcb_arbiter_model

// >>> tb/transfer_ctrl_cycle_bus_timing_bench.sv
// Self-checking bench: random activations against an integer cycle model.
// Assumes the arbiter model on busReq/busGrant; inputs change at negedge.
`timescale 1ns/1ps
module transfer_ctrl_cycle_bus_timing_bench
   import tcb_pkg::*;
;
   logic        mclk = 1'b0, srst = 1'b1, actReq = 1'b0, busGrant, slowGrant = 1'b0;
   logic        fullAddrMode = 1'b0, skipDescRead = 1'b0, threeState = 1'b0;
   logic        srcFixed = 1'b0, dstFixed = 1'b0, blockMode = 1'b0, chainEnable = 1'b0;
   logic [2:0]  cpuPriorityLevel = 3'h0, controllerPriorityLevel = 3'h0, waitCount = 3'h0;
   logic [1:0]  infoRegion = 2'h0, srcRegion = 2'h0, dstRegion = 2'h0, dataSize = 2'h0;
   logic [1:0]  ioWidth = 2'h0, extWidth = 2'h0, srcAddrLow = 2'h0, dstAddrLow = 2'h0;
   logic [7:0]  blockSize = 8'h01, descCount;
   logic        busReq, busy, accessStrobe, activationDone;
   tcb_state_t  phase;
   logic [15:0] cycleTotal;
   logic [31:0] seed = 32'h56fc_f829;
   int          miscompares = 0, n_compared = 0;

   tcb_transfer_controller u_dut (.mclk, .srst, .actReq, .cpuPriorityLevel,
      .controllerPriorityLevel, .busGrant, .fullAddrMode, .skipDescRead, .infoRegion,
      .srcRegion, .dstRegion, .ioWidth, .extWidth, .threeState, .waitCount, .srcFixed,
      .dstFixed, .blockMode, .blockSize, .dataSize, .srcAddrLow, .dstAddrLow, .chainEnable,
      .busReq, .busy, .accessStrobe, .activationDone, .phase, .cycleTotal, .descCount);
   tcb_arbiter_model u_arb (.mclk, .srst, .busReq, .slowGrant, .busGrant);

   // Free-running 125 MHz clock
   initial begin
      forever #4 mclk = ~mclk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Cycles of one access; info accesses are longwords
   function automatic int cost(int r, int s);
      int w = (r == 1) ? int'(ioWidth) : int'(extWidth);
      int u = (s > w) ? 1 << (s - w) : 1;
      if (r == 0) return 1;
      if (r == 1 || !threeState) return 2 * u;
      if (s == 1 && w == 0) return 4 + 2 * waitCount;
      return (3 + waitCount) * u;
   endfunction : cost

   function automatic int split(int s, int a);
      if (s == 2 && a % 2 == 1) return 3;
      if ((s == 1 && a % 2 == 1) || (s == 2 && a == 2)) return 2;
      return 1;
   endfunction : split

   // One descriptor: read (optional), data per element, writeback
   function automatic int descCost(int readIt);
      int p = !blockMode ? 1 : (blockSize == 0 ? 256 : int'(blockSize));
      int k = (srcFixed && dstFixed) ? 1 : (srcFixed || dstFixed) ? 2 : 3;
      return (readIt * (fullAddrMode ? 4 : 3) + k) * cost(infoRegion, 2)
         + p * (split(dataSize, srcAddrLow) * cost(srcRegion, dataSize)
         + split(dataSize, dstAddrLow) * cost(dstRegion, dataSize));
   endfunction : descCost

   // Accesses of one descriptor; each but the internal op gives one strobe
   function automatic int descAcc(int readIt);
      int p = !blockMode ? 1 : (blockSize == 0 ? 256 : int'(blockSize));
      int k = (srcFixed && dstFixed) ? 1 : (srcFixed || dstFixed) ? 2 : 3;
      return readIt * (fullAddrMode ? 4 : 3) + k
         + p * (split(dataSize, srcAddrLow) + split(dataSize, dstAddrLow));
   endfunction : descAcc

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %0d seen %0d", what, exp, seen);
      end
   endtask : check

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_of_test

   // One activation with random settings; lowFirst starts below CPU priority
   task automatic run_one(int i, bit lowFirst);
      int expCyc, expRel, expAcc, p, chain, rel = 0, n = 0, acc = 0;
      logic prevReq = 1'b0;
      @(negedge mclk);
      infoRegion = 2'(rnd() % 2 * 2); // Info in on-chip RAM or external, never on-chip I/O
      srcRegion = i ? 2'(rnd() % 3) : REG_RAM;
      dstRegion = i ? 2'(rnd() % 3) : REG_RAM;
      ioWidth = 2'(rnd() % 3);
      extWidth = 2'(rnd() % 3);
      {threeState, srcFixed, dstFixed, fullAddrMode, skipDescRead, chainEnable} = 6'(rnd());
      blockMode = 1'(rnd()) | (i == 0);
      blockSize = i ? 8'(rnd() % 4 + 1) : 8'h00; // Zero means the largest block
      waitCount = 3'(rnd());
      dataSize = 2'(rnd() % 3);
      srcAddrLow = 2'(rnd());
      dstAddrLow = 2'(rnd());
      slowGrant = 1'(rnd());
      cpuPriorityLevel = 3'(rnd() % 7 + 1);
      controllerPriorityLevel = lowFirst ? cpuPriorityLevel - 3'h1
         : 3'(cpuPriorityLevel + rnd() % (8 - cpuPriorityLevel));
      p = !blockMode ? 1 : (blockSize == 0 ? 256 : int'(blockSize));
      chain = chainEnable;
      expCyc = (skipDescRead ? 0 : cost(infoRegion, 2) + 1) + descCost(!skipDescRead)
         + (chain ? descCost(1) : 0);
      expRel = (skipDescRead ? 0 : 2) + p + 1 + (chain ? p + 2 : 0);
      expAcc = (skipDescRead ? 0 : 1) + descAcc(!skipDescRead) + (chain ? descAcc(1) : 0);
      actReq = 1'b1;
      @(negedge mclk);
      actReq = 1'b0;
      if (lowFirst) begin
         repeat (10) begin
            @(negedge mclk);
            check("busyWhileLow", 32'(busy), 32'h0000_0000);
         end
         controllerPriorityLevel = cpuPriorityLevel;
      end
      while (activationDone !== 1'b1 && n < 20000) begin
         @(negedge mclk);
         n++;
         if (phase === ST_DATA) chainEnable = 1'b0; // Next descriptor ends the chain
         if (prevReq === 1'b1 && busReq === 1'b0) rel++;
         if (accessStrobe === 1'b1) acc++;
         prevReq = busReq;
      end
      if (n >= 20000) begin
         miscompares++;
         end_of_test();
      end else begin
         check("cycleTotal", 32'(cycleTotal), 32'(expCyc));
         check("descCount", 32'(descCount), 32'(chain + 1));
         check("busyAtDone", 32'(busy), 32'h0000_0000);
         check("releases", 32'(rel), 32'(expRel));
         check("strobes", 32'(acc), 32'(expAcc));
      end
   endtask : run_one

   // Reset, then a largest block, a refused start, and random activations
   initial begin
      repeat (5) @(negedge mclk);
      srst = 1'b0;
      check("idleAfterReset", {busReq, busy, 27'h0, phase}, 32'h0000_0000);
      run_one(0, 1'b0);
      run_one(1, 1'b1);
      for (int i = 2; i < 26; i++) begin
         run_one(i, 1'b0);
      end
      end_of_test();
   end
endmodule : transfer_ctrl_cycle_bus_timing_bench
